// ---- hdl/dau_pkg.sv ----
/*
 Shared definitions of the descriptor access unit: field layout, flag bit
 positions, order codes, state encoding and decoding helpers.
 Assumes bit 63 of a 64-bit word is the most significant end of a descriptor.
*/
package dau_pkg;
	// Descriptor fields, most significant end first
	localparam int TYP_HI = 63;
	localparam int TYP_LO = 56;
	localparam int BND_HI = 55;
	localparam int BND_LO = 32;
	localparam int ORG_HI = 31;
	localparam int ORG_LO = 0;
	// Sub-fields of the type byte
	localparam int K_HI = 7;
	localparam int K_LO = 6;
	localparam int SZ_HI = 5;
	localparam int SZ_LO = 3;
	localparam int UNSC_BIT = 2;
	localparam int SUB_HI = 4;
	localparam int SUB_LO = 0;
	localparam logic [1:0] KIND_VEC0 = 2'h0;
	localparam logic [1:0] KIND_STR = 2'h1;
	localparam logic [1:0] KIND_VEC2 = 2'h2;
	localparam logic [1:0] KIND_MISC = 2'h3;
	localparam logic [2:0] SZ_BYTE = 3'h3;
	localparam logic [2:0] SZ_WORD = 3'h5;
	localparam logic [4:0] SUB_LAST_CHK = 5'h02;
	localparam logic [4:0] SUB_IND = 5'h03;
	localparam logic [4:0] SUB_PROC = 5'h04;
	localparam logic [4:0] SUB_EXEC = 5'h10;
	// Unit flag register bit positions (d31 is the least significant bit)
	localparam int FL_OVR = 0;
	localparam int FL_ITS = 1;
	localparam int FL_EXEC = 2;
	localparam int FL_SHORT = 3;
	localparam int FL_TRUNC = 4;
	localparam int FL_BFAIL = 5;
	localparam int FL_SHORT_INH = 6;
	localparam int FL_TRUNC_INH = 7;
	localparam int FL_BFAIL_INH = 8;
	localparam int FL_RDO = 9;
	// Steps and offsets
	localparam logic [31:0] STK_STEP = 32'h2;
	localparam int STK_SHIFT = 2;
	localparam logic [31:0] ELEM1_OFS = 32'h4;
	localparam logic [31:0] ELEM2_OFS = 32'h8;
	localparam logic [31:0] XADV_STEP = 32'h3;

	typedef enum logic [4:0] {
		OP_STACK = 5'h00, OP_LD_ORG = 5'h01, OP_LD_FULL = 5'h02, OP_STK_LD = 5'h03,
		OP_STORE = 5'h04, OP_LD_BND = 5'h05, OP_XLD_ORG = 5'h06, OP_XLD_FULL = 5'h07,
		OP_XSTORE = 5'h08, OP_XLD_BND = 5'h09, OP_ADV = 5'h0A, OP_XADV = 5'h0B,
		OP_SADV = 5'h0C, OP_ADVRD = 5'h0D, OP_RADJ = 5'h0E, OP_OVCHK = 5'h0F,
		OP_DOPE1 = 5'h10, OP_DOPE2 = 5'h11
	} dau_op_e;
	typedef enum logic [1:0] {SEC_NONE = 2'h0, SEC_IDX = 2'h1, SEC_ZERO = 2'h2} dau_sec_e;
	typedef enum logic [2:0] {
		SEL_FLAG = 3'h0, SEL_MAIN = 3'h1, SEL_SEC = 3'h2, SEL_MTOP = 3'h3,
		SEL_STOP = 3'h4, SEL_STK = 3'h5
	} dau_sel_e;
	typedef enum logic [3:0] {
		S_IDLE = 4'h0, S_WR = 4'h1, S_SECRD = 4'h2, S_IND = 4'h3, S_RDD0 = 4'h4,
		S_E0 = 4'h5, S_E1 = 4'h6, S_E2 = 4'h7, S_ADV = 4'h8
	} dau_st_e;

	typedef struct packed {
		dau_op_e op;
		dau_sec_e sec;
		logic [63:0] oper;
		logic [31:0] addr;
	} dau_order_s;
	typedef struct packed {
		logic req;
		logic we;
		logic [31:0] addr;
		logic [63:0] wdata;
	} dau_mem_s;
	typedef struct packed {
		dau_st_e st;
		dau_op_e op;
		dau_sec_e sec;
		logic [63:0] oper;
		logic [63:0] mp;
		logic [63:0] xp;
		logic [31:0] flag;
		logic [31:0] stk;
		logic [31:0] b;
		dau_mem_s mem;
		logic ind;
		logic done;
		logic intr;
		logic call;
		logic bupd;
	} dau_state_s;
	localparam dau_state_s STATE_RST = '0;

	function automatic logic [31:0] dau_scale(input logic [7:0] typ, input logic [31:0] m);
		logic [2:0] sz;
		sz = typ[SZ_HI:SZ_LO];
		if ((typ[K_HI:K_LO] == KIND_VEC0 || typ[K_HI:K_LO] == KIND_VEC2) && !typ[UNSC_BIT]
			&& sz > SZ_BYTE)
			return m << (sz - SZ_BYTE);
		return m;
	endfunction
	function automatic logic dau_checked(input logic [7:0] typ);
		return typ[K_HI:K_LO] != KIND_MISC || typ[SUB_HI:SUB_LO] <= SUB_LAST_CHK;
	endfunction
	function automatic dau_mem_s dau_req(input logic we, input logic [31:0] a,
		input logic [63:0] w);
		return '{req: 1'b1, we: we, addr: a, wdata: w};
	endfunction
	function automatic logic [31:0] dau_elem(input logic [31:0] a, input logic [63:0] w);
		return a[2] ? w[31:0] : w[63:32];
	endfunction
endpackage

// ---- hdl/dau_adv.sv ----
/*
 Descriptor advance datapath: adds a scaled signed modifier to the origin,
 takes it from the bound and reports a bound check failure.
 Purely combinational; the caller decides whether the failure counts.
*/
`timescale 1ns/1ps
module dau_adv import dau_pkg::*; (
	input wire logic [63:0] desc,
	input wire logic [31:0] modv,
	input wire logic keep_bound,
	output logic [63:0] result,
	output logic bound_fail
);
	logic [7:0] typ;
	always_comb begin
		typ = desc[TYP_HI:TYP_LO];
		result = desc;
		result[ORG_HI:ORG_LO] = desc[ORG_HI:ORG_LO] + dau_scale(typ, modv);
		if (!keep_bound) begin
			result[BND_HI:BND_LO] = desc[BND_HI:BND_LO] - modv[23:0];
		end
		// Negative modifier fails; the unsigned compare alone would fail it too
		bound_fail = !keep_bound && dau_checked(typ)
			&& (modv[31] || modv >= {8'h00, desc[BND_HI:BND_LO]});
	end
endmodule // dau_adv

// ---- hdl/dau_core.sv ----
/*
 Descriptor access unit: main and secondary pointer registers, unit flag
 register, stack front pointer, load/store/stack orders and structure access
 orders with bound checking.
 Assumes one order at a time from the pipeline and a store that answers each
 request with a one-cycle ack; B register value is offered on b_in.
*/
`timescale 1ns/1ps
// Functional notes
// - Pointer registers: type 8, bound 24, origin 32.
// - Flag register holds overlap, type and fault flags.
// - Flag register holds three inhibits and read-only flag.
// - Type/size and subtype misuse always interrupt.
// - Other faults interrupt only when not inhibited.
// - Flag, pointers and upper halves are register operands.
// - Stack: advance front by two, then write.
// - Load origin from operand low word only.
// - Full load and store move all bits.
// - Stack-and-load pushes, then loads all bits.
// - Load bound from operand bits 0-23.
// - Secondary operand: load descriptor, then overwrite part.
// - Stack-and-load pushes before descriptor is loaded.
// - Modify adds scaled modifier, subtracts from bound.
// - Modify bound check unless inhibited, listed types.
// - Modify indirect loads descriptor; procedure types call.
// - Secondary modify acts on second register; types illegal.
// - Side modify keeps bound; modify-and-read reloads.
// - Reverse adjust loads top, adds bottom half.
// - Overlap check sets bit when within second bound.
// - Subscript orders walk three dope vector elements.
module dau_core import dau_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic exec_mode,
	input wire logic ord_valid,
	input wire dau_order_s ord,
	output logic ord_ready,
	output logic done,
	output logic intr,
	output logic call_req,
	input wire logic [31:0] b_in,
	output logic [31:0] b_out,
	output logic b_upd,
	input wire logic reg_we,
	input wire dau_sel_e reg_sel,
	input wire logic [63:0] reg_wdata,
	output logic [63:0] reg_rdata,
	output logic reg_ready,
	output dau_mem_s mem,
	input wire logic mem_ack,
	input wire logic [63:0] mem_rdata
);
	dau_state_s q;
	dau_state_s n;
	logic [31:0] ev;
	logic [63:0] adv_m_res;
	logic [63:0] adv_x_res;
	logic adv_m_fail;
	logic adv_x_fail;
	logic sub_op;
	logic ovr_hit;
	logic [63:0] prod;
	logic [31:0] elem;
	logic [7:0] dtyp;
	logic [7:0] xtyp;

	function automatic logic [63:0] merge(input dau_op_e op, input logic [63:0] old,
		input logic [63:0] val);
		logic [63:0] r;
		r = val;
		if (op == OP_LD_ORG || op == OP_XLD_ORG) begin
			r = {old[63:32], val[ORG_HI:ORG_LO]};
		end else if (op == OP_LD_BND || op == OP_XLD_BND) begin
			r = {old[TYP_HI:TYP_LO], val[23:0], old[ORG_HI:ORG_LO]};
		end
		return r;
	endfunction
	function automatic logic [31:0] sec_addr(input logic [63:0] desc, input dau_sec_e s,
		input logic [31:0] idx);
		return desc[ORG_HI:ORG_LO] + dau_scale(desc[TYP_HI:TYP_LO], s == SEC_IDX ? idx : 32'h0);
	endfunction
	function automatic logic [31:0] intr_mask(input logic [31:0] f);
		logic [31:0] m;
		m = '0;
		m[FL_ITS] = 1'b1;
		m[FL_EXEC] = 1'b1;
		m[FL_SHORT] = !f[FL_SHORT_INH];
		m[FL_TRUNC] = !f[FL_TRUNC_INH];
		m[FL_BFAIL] = !f[FL_BFAIL_INH];
		return m;
	endfunction

	assign sub_op = q.op == OP_DOPE1 || q.op == OP_DOPE2;
	assign dtyp = q.mp[TYP_HI:TYP_LO];
	assign xtyp = q.xp[TYP_HI:TYP_LO];
	assign elem = dau_elem(q.mem.addr, mem_rdata);
	assign prod = q.b * elem;
	assign ovr_hit = !ord.oper[31] && ord.oper[31:0] < {8'h00, q.xp[BND_HI:BND_LO]};

	dau_adv adv_main (
		.desc(q.mp),
		.modv(sub_op ? q.b : q.oper[31:0]),
		.keep_bound(q.op == OP_SADV),
		.result(adv_m_res),
		.bound_fail(adv_m_fail)
	);
	dau_adv adv_sec (
		.desc(q.xp),
		.modv(sub_op ? XADV_STEP : q.oper[31:0]),
		.keep_bound(1'b0),
		.result(adv_x_res),
		.bound_fail(adv_x_fail)
	);

	always_comb begin
		n = q;
		ev = '0;
		n.done = 1'b0;
		n.intr = 1'b0;
		n.call = 1'b0;
		n.bupd = 1'b0;
		unique case (q.st)
			S_IDLE: begin
				if (reg_we) begin
					unique case (reg_sel)
						SEL_FLAG: n.flag = reg_wdata[31:0];
						SEL_MAIN: n.mp = reg_wdata;
						SEL_SEC: n.xp = reg_wdata;
						SEL_MTOP: n.mp[63:32] = reg_wdata[31:0];
						SEL_STOP: n.xp[63:32] = reg_wdata[31:0];
						SEL_STK: n.stk = reg_wdata[31:0];
						default: ;
					endcase
				end else if (ord_valid) begin
					n.op = ord.op;
					n.sec = ord.sec;
					n.oper = ord.oper;
					n.b = b_in;
					n.ind = 1'b0;
					n.done = 1'b1;
					unique case (ord.op)
						OP_STACK: begin
							n.stk = q.stk + STK_STEP;
							n.mem = dau_req(1'b1, (q.stk + STK_STEP) << STK_SHIFT, ord.oper);
							n.st = S_WR;
							n.done = 1'b0;
						end
						OP_STK_LD: begin
							// Old contents go out before anything is loaded
							n.stk = q.stk + STK_STEP;
							n.mem = dau_req(1'b1, (q.stk + STK_STEP) << STK_SHIFT, q.mp);
							n.st = S_WR;
							n.done = 1'b0;
						end
						OP_STORE, OP_XSTORE: begin
							// Addressing form is ignored; the pipeline never pairs them
							n.mem = dau_req(1'b1, ord.addr, ord.op == OP_STORE ? q.mp : q.xp);
							n.st = S_WR;
							n.done = 1'b0;
						end
						OP_LD_ORG, OP_LD_FULL, OP_LD_BND: begin
							if (ord.sec != SEC_NONE) begin
								n.mp = ord.oper;
								n.mem = dau_req(1'b0, sec_addr(ord.oper, ord.sec, b_in), '0);
								n.st = S_SECRD;
								n.done = 1'b0;
							end else begin
								n.mp = merge(ord.op, q.mp, ord.oper);
							end
						end
						OP_XLD_ORG, OP_XLD_FULL, OP_XLD_BND: begin
							if (ord.sec != SEC_NONE) begin
								n.xp = ord.oper;
								n.mem = dau_req(1'b0, sec_addr(ord.oper, ord.sec, b_in), '0);
								n.st = S_SECRD;
								n.done = 1'b0;
							end else begin
								n.xp = merge(ord.op, q.xp, ord.oper);
							end
						end
						OP_ADV, OP_XADV, OP_SADV, OP_ADVRD: begin
							n.st = S_ADV;
							n.done = 1'b0;
						end
						OP_RADJ: begin
							n.mp = {ord.oper[63:32], q.mp[31:0] + ord.oper[31:0]};
						end
						OP_OVCHK: begin
							n.flag[FL_OVR] = ovr_hit;
						end
						OP_DOPE1, OP_DOPE2: begin
							if (ord.op == OP_DOPE1) begin
								n.xp = ord.oper;
								n.mp = '0;
							end
							n.st = S_E0;
							n.done = 1'b0;
						end
						default: n.done = 1'b1;
					endcase
				end
			end
			S_WR: begin
				if (mem_ack) begin
					n.mem.req = 1'b0;
					n.st = S_IDLE;
					n.done = 1'b1;
					if (q.op == OP_STK_LD) begin
						n.mp = q.oper;
						if (q.sec != SEC_NONE) begin
							n.mem = dau_req(1'b0, sec_addr(q.oper, q.sec, q.b), '0);
							n.st = S_SECRD;
							n.done = 1'b0;
						end
					end
				end
			end
			S_SECRD: begin
				if (mem_ack) begin
					n.mem.req = 1'b0;
					if (q.op == OP_XLD_ORG || q.op == OP_XLD_FULL || q.op == OP_XLD_BND) begin
						n.xp = merge(q.op, q.xp, mem_rdata);
					end else begin
						n.mp = merge(q.op, q.mp, mem_rdata);
					end
					n.st = S_IDLE;
					n.done = 1'b1;
				end
			end
			S_IND: begin
				if (mem_ack) begin
					n.mem.req = 1'b0;
					n.mp = mem_rdata;
					n.ind = 1'b1;
					n.st = S_ADV;
				end
			end
			S_RDD0: begin
				if (mem_ack) begin
					n.mem.req = 1'b0;
					n.mp = mem_rdata;
					n.st = S_IDLE;
					n.done = 1'b1;
				end
			end
			S_E0: begin
				if (!q.mem.req) begin
					// Dope vector must hold 32-bit elements in a vector descriptor
					if ((xtyp[K_HI:K_LO] != KIND_VEC0 && xtyp[K_HI:K_LO] != KIND_VEC2)
						|| xtyp[SZ_HI:SZ_LO] != SZ_WORD) begin
						ev[FL_ITS] = 1'b1;
						n.st = S_IDLE;
						n.done = 1'b1;
					end else begin
						n.mem = dau_req(1'b0, q.xp[ORG_HI:ORG_LO], '0);
					end
				end else if (mem_ack) begin
					n.b = q.b - elem;
					n.mem = dau_req(1'b0, q.xp[ORG_HI:ORG_LO] + ELEM1_OFS, '0);
					n.st = S_E1;
				end
			end
			S_E1: begin
				if (mem_ack) begin
					n.b = prod[31:0];
					n.mem = dau_req(1'b0, q.xp[ORG_HI:ORG_LO] + ELEM2_OFS, '0);
					n.st = S_E2;
				end
			end
			S_E2: begin
				if (mem_ack) begin
					n.mem.req = 1'b0;
					n.mp[BND_HI:BND_LO] = elem[23:0];
					n.bupd = 1'b1;
					n.st = S_ADV;
				end
			end
			S_ADV: begin
				n.st = S_IDLE;
				n.done = 1'b1;
				if (q.op == OP_XADV) begin
					if (xtyp[K_HI:K_LO] == KIND_MISC && xtyp[SUB_HI:SUB_LO] >= SUB_IND) begin
						ev[FL_ITS] = 1'b1;
					end else begin
						n.xp = adv_x_res;
						ev[FL_BFAIL] = adv_x_fail;
					end
				end else if (dtyp[K_HI:K_LO] == KIND_MISC && dtyp[SUB_HI:SUB_LO] >= SUB_EXEC
					&& !exec_mode) begin
					ev[FL_EXEC] = 1'b1;
				end else if (dtyp[K_HI:K_LO] == KIND_MISC && dtyp[SUB_HI:SUB_LO] == SUB_IND
					&& !q.ind) begin
					n.mem = dau_req(1'b0, q.mp[ORG_HI:ORG_LO], '0);
					n.st = S_IND;
					n.done = 1'b0;
				end else begin
					n.call = dtyp[K_HI:K_LO] == KIND_MISC && dtyp[SUB_HI:SUB_LO] >= SUB_PROC
						&& !q.ind;
					n.mp = adv_m_res;
					ev[FL_BFAIL] = adv_m_fail;
					if (sub_op) begin
						n.xp = adv_x_res;
						ev[FL_BFAIL] = adv_m_fail | adv_x_fail;
					end
					if (q.op == OP_ADVRD) begin
						n.mem = dau_req(1'b0, adv_m_res[ORG_HI:ORG_LO], '0);
						n.st = S_RDD0;
						n.done = 1'b0;
					end
				end
			end
			default: n = STATE_RST;
		endcase
		// Detection beats a simultaneous software write of the same flag
		n.flag = n.flag | ev;
		n.intr = |(ev & intr_mask(q.flag));
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q <= STATE_RST;
		end else begin
			q <= n;
		end
	end

	assign ord_ready = q.st == S_IDLE && !reg_we;
	assign reg_ready = q.st == S_IDLE;
	assign done = q.done;
	assign intr = q.intr;
	assign call_req = q.call;
	assign b_out = q.b;
	assign b_upd = q.bupd;
	assign mem = q.mem;

	always_comb begin
		unique case (reg_sel)
			SEL_FLAG: reg_rdata = {32'h0, q.flag};
			SEL_MAIN: reg_rdata = q.mp;
			SEL_SEC: reg_rdata = q.xp;
			SEL_MTOP: reg_rdata = {32'h0, q.mp[63:32]};
			SEL_STOP: reg_rdata = {32'h0, q.xp[63:32]};
			SEL_STK: reg_rdata = {32'h0, q.stk};
			default: reg_rdata = '0;
		endcase
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	AST_STACK_PUSH: assert property ((ord_valid && ord_ready && ord.op == OP_STACK) |=>
		(mem.req && mem.we && mem.addr == ($past(q.stk) + STK_STEP) << STK_SHIFT
		&& mem.wdata == $past(ord.oper)))
		else $error("stack push address or data wrong");
	AST_LOAD_ORIGIN: assert property ((ord_valid && ord_ready && ord.op == OP_LD_ORG
		&& ord.sec == SEC_NONE) |=> (q.mp[31:0] == $past(ord.oper[31:0])
		&& q.mp[63:32] == $past(q.mp[63:32])))
		else $error("origin load disturbed other bits");
	AST_LOAD_FULL: assert property ((ord_valid && ord_ready && ord.op == OP_LD_FULL
		&& ord.sec == SEC_NONE) |=> (q.mp == $past(ord.oper) && done))
		else $error("full load wrong");
	AST_LOAD_BOUND: assert property ((ord_valid && ord_ready && ord.op == OP_LD_BND
		&& ord.sec == SEC_NONE) |=> (q.mp[55:32] == $past(ord.oper[23:0])
		&& q.mp[63:56] == $past(q.mp[63:56]) && q.mp[31:0] == $past(q.mp[31:0])))
		else $error("bound load wrong");
	AST_PUSH_FIRST: assert property ((ord_valid && ord_ready && ord.op == OP_STK_LD) |=>
		(mem.we && mem.wdata == $past(q.mp)) [*1] ##0 q.st == S_WR)
		else $error("stack-and-load did not push old value");
	AST_REV_ADJ: assert property ((ord_valid && ord_ready && ord.op == OP_RADJ) |=>
		(q.mp[63:32] == $past(ord.oper[63:32])
		&& q.mp[31:0] == $past(q.mp[31:0]) + $past(ord.oper[31:0])))
		else $error("reverse adjust wrong");
	AST_OVERLAP: assert property ((ord_valid && ord_ready && ord.op == OP_OVCHK) |=>
		(q.flag[FL_OVR] == (!$past(ord.oper[31])
		&& $past(ord.oper[31:0]) < {8'h00, $past(q.xp[55:32])})))
		else $error("overlap bit wrong");
	AST_ITS_ALWAYS: assert property (($rose(q.flag[FL_ITS]) && !$past(reg_we)) |-> intr)
		else $error("type/size fault without interrupt");
	AST_BCH_MASK: assert property (($rose(q.flag[FL_BFAIL]) && $past(q.flag[FL_BFAIL_INH])
		&& !$rose(q.flag[FL_ITS]) && !$past(reg_we)) |-> !intr)
		else $error("inhibited bound fault interrupted");
	// An indirect descriptor is replaced first, so its bound may change legally
	AST_SIDE_BOUND: assert property ((q.st == S_ADV && q.op == OP_SADV
		&& !(dtyp[K_HI:K_LO] == KIND_MISC && dtyp[SUB_HI:SUB_LO] == SUB_IND && !q.ind)) |=>
		(q.mp[55:32] == $past(q.mp[55:32]) && !$rose(q.flag[FL_BFAIL])))
		else $error("side advance touched bound");
endmodule // dau_core

// ---- dv/dau_store_model.sv ----
/*
 Store model for the descriptor access unit: answers each request with a
 one-cycle ack after lat idle cycles, keeps 64-bit words by 8-byte address.
 Assumes the unit holds its request until the ack edge.
*/
`timescale 1ns/1ps
module dau_store_model import dau_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [3:0] lat,
	input wire dau_mem_s mem,
	output logic mem_ack,
	output logic [63:0] mem_rdata
);
	logic [63:0] store [logic [28:0]];
	logic [3:0] cnt;
	always @(posedge clk) begin
		if (sys_rst) begin
			mem_ack <= 1'b0;
			cnt <= 4'h0;
			mem_rdata <= 64'hA5A5_5A5A_A5A5_5A5A;
		end else if (mem.req && !mem_ack && cnt >= lat) begin
			mem_ack <= 1'b1;
			cnt <= 4'h0;
			if (mem.we)
				store[mem.addr[31:3]] = mem.wdata;
			mem_rdata <= store.exists(mem.addr[31:3]) ? store[mem.addr[31:3]] : 64'h0;
		end else begin
			// Data is only valid with ack; otherwise it toggles so nothing stale passes
			mem_ack <= 1'b0;
			cnt <= (mem.req && !mem_ack) ? cnt + 4'h1 : 4'h0;
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule // dau_store_model

// ---- dv/descriptor_access_unit_tb_top.sv ----
/*
 Testbench of the descriptor access unit: register port and order tasks,
 then directed tests with expected values.
 Assumes dau_store_model stands on the store side.
*/
`timescale 1ns/1ps
module descriptor_access_unit_tb_top import dau_pkg::*;;
	logic clk = 0;
	logic sys_rst = 1;
	logic exec_mode = 0;
	logic ord_valid = 0;
	logic reg_we = 0;
	dau_order_s ord = '0;
	dau_sel_e reg_sel = SEL_FLAG;
	logic [63:0] reg_wdata = '0;
	logic [31:0] b_in = '0;
	logic [3:0] lat = 4'h0;
	logic ord_ready, done, intr, call_req, b_upd, reg_ready, mem_ack;
	logic [31:0] b_out;
	logic [63:0] reg_rdata, mem_rdata;
	dau_mem_s mem;
	int err_count = 0;
	int comparisons = 0;
	int n_intr, n_upd, n_call, n_busy;
	always #5 clk = ~clk;
	dau_core uut (.clk(clk), .sys_rst(sys_rst), .exec_mode(exec_mode), .ord_valid(ord_valid),
		.ord(ord), .ord_ready(ord_ready), .done(done), .intr(intr), .call_req(call_req),
		.b_in(b_in), .b_out(b_out), .b_upd(b_upd), .reg_we(reg_we), .reg_sel(reg_sel),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ready(reg_ready), .mem(mem),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata));
	dau_store_model u_store (.clk(clk), .sys_rst(sys_rst), .lat(lat), .mem(mem),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata));
	task automatic finish_test();
		if (err_count == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd(input dau_sel_e s, input logic [63:0] exp);
		reg_sel = s;
		tick();
		chk(reg_rdata, exp);
	endtask
	task automatic wr(input dau_sel_e s, input logic [63:0] v);
		reg_we = 1;
		reg_sel = s;
		reg_wdata = v;
		tick();
		reg_we = 0;
		tick();
	endtask
	// Holds the order for one accepting edge, then waits for done under a bound
	task automatic run(input dau_op_e op, input dau_sec_e sec, input logic [63:0] v);
		int i;
		ord_valid = 1;
		ord = '{op, sec, v, 32'h800};
		tick();
		ord_valid = 0;
		n_intr = 0;
		n_upd = 0;
		n_call = 0;
		n_busy = 0;
		i = 0;
		// A register-only order already shows done right after the accepting edge
		forever begin
			n_intr += int'(intr === 1'b1);
			n_upd += int'(b_upd === 1'b1);
			n_call += int'(call_req === 1'b1);
			if (done === 1'b1 || i >= 60)
				break;
			n_busy += int'(reg_ready !== 1'b0 || ord_ready !== 1'b0);
			tick();
			i++;
		end
		chk(64'(done), 64'h1);
		chk(64'(n_busy), 64'h0);
	endtask
	function automatic logic [63:0] ds(logic [7:0] t, logic [23:0] b, logic [31:0] o);
		return {t, b, o};
	endfunction
	initial begin
		repeat (16) @(posedge clk);
		#1 sys_rst = 0;
		for (int k = 0; k < 6; k++)
			rd(dau_sel_e'(k[2:0]), 64'h0);
		wr(SEL_MAIN, ds(8'h2C, 24'h10, 32'h1000));
		wr(SEL_MTOP, 64'h5A5A_5A5A);
		rd(SEL_MAIN, 64'h5A5A_5A5A_0000_1000);
		rd(SEL_MTOP, 64'h5A5A_5A5A);
		wr(SEL_FLAG, 64'hFFFF_FFFF_0000_01C0);
		rd(SEL_FLAG, 64'h1C0);
		wr(SEL_FLAG, 64'h0);
		run(OP_LD_FULL, SEC_NONE, ds(8'h28, 24'hA, 32'h2000));
		rd(SEL_MAIN, ds(8'h28, 24'hA, 32'h2000));
		run(OP_LD_ORG, SEC_NONE, 64'hFFFF_FFFF_0000_3000);
		rd(SEL_MAIN, ds(8'h28, 24'hA, 32'h3000));
		run(OP_LD_BND, SEC_NONE, 64'hFFFF_FFFF_FF12_3456);
		rd(SEL_MAIN, ds(8'h28, 24'h123456, 32'h3000));
		run(OP_XLD_FULL, SEC_NONE, ds(8'h28, 24'h1, 32'h1));
		run(OP_XLD_ORG, SEC_NONE, 64'hFFFF_FFFF_0000_4000);
		run(OP_XLD_BND, SEC_NONE, 64'hFFFF_FFFF_FF00_0009);
		rd(SEL_SEC, ds(8'h28, 24'h9, 32'h4000));
		rd(SEL_STOP, 64'h2800_0009);
		run(OP_STORE, SEC_NONE, 64'h0);
		chk(u_store.store[29'h100], ds(8'h28, 24'h123456, 32'h3000));
		// Slow store for the stack and secondary-operand loads that follow
		wr(SEL_STK, 64'h100);
		lat = 4'h3;
		run(OP_STACK, SEC_NONE, 64'h0123_4567_89AB_CDEF);
		chk(u_store.store[29'h81], 64'h0123_4567_89AB_CDEF);
		rd(SEL_STK, 64'h102);
		run(OP_STK_LD, SEC_NONE, ds(8'h2C, 24'h10, 32'h1000));
		chk(u_store.store[29'h82], ds(8'h28, 24'h123456, 32'h3000));
		rd(SEL_MAIN, ds(8'h2C, 24'h10, 32'h1000));
		u_store.store[29'h120] = 64'h7777_0000_8888_0000;
		run(OP_STK_LD, SEC_ZERO, ds(8'h2C, 24'h10, 32'h900));
		chk(u_store.store[29'h83], ds(8'h2C, 24'h10, 32'h1000));
		rd(SEL_MAIN, 64'h7777_0000_8888_0000);
		u_store.store[29'hA01] = 64'h1111_2222_3333_4444;
		b_in = 32'h8;
		run(OP_LD_FULL, SEC_IDX, ds(8'h2C, 24'h10, 32'h5000));
		rd(SEL_MAIN, 64'h1111_2222_3333_4444);
		u_store.store[29'hA02] = 64'hAAAA_BBBB_0000_6000;
		run(OP_LD_ORG, SEC_ZERO, ds(8'h2C, 24'h10, 32'h5010));
		rd(SEL_MAIN, ds(8'h2C, 24'h10, 32'h6000));
		lat = 4'h0;
		run(OP_LD_FULL, SEC_NONE, ds(8'h28, 24'hA, 32'h100));
		run(OP_ADV, SEC_NONE, 64'h3);
		rd(SEL_MAIN, ds(8'h28, 24'h7, 32'h10C));
		chk(64'(n_intr), 64'h0);
		run(OP_ADV, SEC_NONE, 64'h7);
		chk(64'(n_intr), 64'h1);
		rd(SEL_FLAG, 64'h20);
		wr(SEL_FLAG, 64'h100);
		run(OP_ADV, SEC_NONE, 64'hFFFF_FFFF);
		chk(64'(n_intr), 64'h0);
		rd(SEL_FLAG, 64'h120);
		wr(SEL_FLAG, 64'h0);
		run(OP_LD_FULL, SEC_NONE, ds(8'h2C, 24'h4, 32'h200));
		run(OP_SADV, SEC_NONE, 64'h9);
		rd(SEL_MAIN, ds(8'h2C, 24'h4, 32'h209));
		chk(64'(n_intr), 64'h0);
		run(OP_RADJ, SEC_NONE, 64'h2800_0020_0000_0010);
		rd(SEL_MAIN, 64'h2800_0020_0000_0219);
		run(OP_OVCHK, SEC_NONE, 64'h8);
		rd(SEL_FLAG, 64'h1);
		run(OP_OVCHK, SEC_NONE, 64'h9);
		rd(SEL_FLAG, 64'h0);
		run(OP_OVCHK, SEC_NONE, 64'hFFFF_FFFF);
		rd(SEL_FLAG, 64'h0);
		// Inhibits all set: type faults must still interrupt
		wr(SEL_SEC, ds(8'hC3, 24'h9, 32'h4000));
		wr(SEL_FLAG, 64'h1C0);
		run(OP_XADV, SEC_NONE, 64'h1);
		chk(64'(n_intr), 64'h1);
		rd(SEL_FLAG, 64'h1C2);
		wr(SEL_FLAG, 64'h0);
		run(OP_LD_FULL, SEC_NONE, ds(8'hD0, 24'h9, 32'h100));
		run(OP_ADV, SEC_NONE, 64'h1);
		chk(64'(n_intr), 64'h1);
		rd(SEL_FLAG, 64'h4);
		wr(SEL_FLAG, 64'h0);
		// Executive mode: same descriptor is a legal procedure, no misuse flag
		exec_mode = 1;
		run(OP_ADV, SEC_NONE, 64'h1);
		chk(64'(n_intr), 64'h0);
		chk(64'(n_call), 64'h1);
		rd(SEL_FLAG, 64'h0);
		rd(SEL_MAIN, ds(8'hD0, 24'h8, 32'h101));
		exec_mode = 0;
		u_store.store[29'hA0] = ds(8'h2C, 24'h10, 32'h600);
		run(OP_LD_FULL, SEC_NONE, ds(8'hC3, 24'h0, 32'h500));
		run(OP_ADV, SEC_NONE, 64'h4);
		rd(SEL_MAIN, ds(8'h2C, 24'hC, 32'h604));
		chk(64'(n_call), 64'h0);
		chk(64'(n_intr), 64'h0);
		u_store.store[29'hC1] = 64'h1234_5678_9ABC_DEF0;
		run(OP_ADVRD, SEC_NONE, 64'h4);
		rd(SEL_MAIN, 64'h1234_5678_9ABC_DEF0);
		u_store.store[29'hE00] = {32'd2, 32'd4};
		u_store.store[29'hE01] = {32'd20, 32'd1};
		u_store.store[29'hE02] = {32'd3, 32'd30};
		lat = 4'h2;
		b_in = 32'd5;
		run(OP_DOPE1, SEC_NONE, ds(8'h28, 24'h9, 32'h7000));
		rd(SEL_MAIN, ds(8'h00, 24'd8, 32'd12));
		rd(SEL_SEC, ds(8'h28, 24'h6, 32'h700C));
		chk(64'(b_out), 64'd12);
		chk(64'(n_upd), 64'h1);
		b_in = 32'd3;
		run(OP_DOPE2, SEC_NONE, 64'h0);
		rd(SEL_MAIN, ds(8'h00, 24'd24, 32'd18));
		rd(SEL_SEC, ds(8'h28, 24'h3, 32'h7018));
		chk(64'(b_out), 64'd6);
		chk(64'(n_intr), 64'h0);
		finish_test();
	end
	initial begin
		#200000;
		err_count++;
		finish_test();
	end
endmodule // descriptor_access_unit_tb_top
